// [inc/rps_params.svh]
// timing counts and reset defaults of the reset pin sequencer
// Functional notes
// - An external reset may wait for the end of the bus cycle or the bus monitor timeout before it acts.
// - While reset is active every integration-unit pin is high impedance or at its inactive level.
// - After an external reset is latched and the pin is seen released, the pin is driven low 512 more cycles.
// - An internal reset request drives the reset pin low for at least 512 cycles.
// - If the internal request is still active after 512 cycles, the pin stays driven until it drops.
// - After the drive period the pin floats for 10 cycles and is then sampled; high starts exception processing.
// - If the sampled pin is low it is driven 512 more cycles and then released and tested again.
// - At power-on the reset pin stays asserted until the synthesizer locks and 512 more cycles pass.
// - Peripheral modules reset only after the internal reset has been active four consecutive clocks.
// - Out of reset other modules' pins are general ports with bidirectional ports as inputs.
// - Those defaults come from clearing pin-function enables and port direction registers.
// - Three-state control held 10 cycles puts every output driver in high impedance.
// - With the external clock source strapped, 10 external clock pulses after assertion are counted instead.
// - Once three-state control takes effect only a power-down and restart resumes operation.
// - Reset handling runs on the system clock output and waits while that clock is stopped.
// - Reset sampling and pin transitions are qualified by the system clock output.
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

`define RPS_CNT_W        10
`define RPS_DRIVE_LAST   10'h1ff
`define RPS_REL_LAST     10'h009
`define RPS_TSC_W        4
`define RPS_TSC_LAST     4'h9
`define RPS_RUN_W        3
`define RPS_PERIPH_RUN   3'h4
`define RPS_TMO_W        6
`define RPS_BUS_TMO_LAST 6'h3f
`define RPS_PORT_W       8

`endif

// [inc/rps_pkg.sv]
// types of the reset pin sequencer
package rps_pkg;
  typedef enum logic [2:0] {
    RPS_POR      = 3'h0,
    RPS_POR_LOCK = 3'h1,
    RPS_IDLE     = 3'h2,
    RPS_EXT_WAIT = 3'h3,
    RPS_DRIVE    = 3'h4,
    RPS_RELEASE  = 3'h5
  } rps_state_type;

  typedef struct packed {
    rps_state_type state;
    logic [9:0]    cnt;
    logic          sync1;
    logic          sync2;
    logic          ext_pend;
    logic [5:0]    tmo;
    logic [2:0]    run;
    logic          periph_rst;
    logic          exc;
    logic [3:0]    tsc_cnt;
    logic          hiz;
    logic          ext_src;
  } rps_regs_type;
endpackage

// [hdl/rps_sequencer.sv]
// reset pin sequencer: pin drive/release/test, power-on, three-state
`include "rps_params.svh"

module rps_sequencer (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_rst_pin_in,
  output logic                         o_rst_pin_out,
  output logic                         o_rst_pin_oe,
  input  wire logic                    i_int_rst_req,
  input  wire logic                    i_bus_cycle_end,
  input  wire logic                    i_synth_lock,
  input  wire logic                    i_clock_source_select,
  input  wire logic                    i_ext_clk_pulse,
  input  wire logic                    i_three_state_control,
  output logic                         o_reset_active,
  output logic                         o_sim_pins_safe,
  output logic                         o_periph_rst,
  output logic                         o_reset_exception,
  output logic                         o_outputs_hiz,
  output logic [`RPS_PORT_W-1:0]       o_pin_func_en_clr,
  output logic [`RPS_PORT_W-1:0]       o_port_dir_clr
);

  rps_pkg::rps_regs_type q;
  rps_pkg::rps_regs_type d;
  logic                  pin_high;
  logic                  active;
  logic                  drive_done;
  logic                  rel_done;
  logic                  tsc_tick;
  logic                  ext_src_now;

  // only the second stage is ever looked at
  assign pin_high   = q.sync2;
  assign active     = (q.state != rps_pkg::RPS_IDLE);
  assign drive_done = (q.cnt == `RPS_DRIVE_LAST);
  assign rel_done   = (q.cnt == `RPS_REL_LAST);
  // strap not latched yet in power-on: read it directly, else the first
  // cycle after reset is miscounted as a system clock tick
  assign ext_src_now = (q.state == rps_pkg::RPS_POR) ?
                       ~i_clock_source_select : q.ext_src;
  // vco source counts our clock, external source counts its pulses
  assign tsc_tick   = ext_src_now ? i_ext_clk_pulse : 1'b1;

  always_comb begin
    d       = q;
    d.sync1 = i_rst_pin_in;
    d.sync2 = q.sync1;
    d.exc   = 1'b0;

    // strap is caught while power-on reset is held
    if (q.state == rps_pkg::RPS_POR) begin
      d.ext_src = ~i_clock_source_select;
    end

    unique case (q.state)
      rps_pkg::RPS_POR: begin
        if (i_synth_lock) begin
          d.state = rps_pkg::RPS_POR_LOCK;
          d.cnt   = '0;
        end
      end
      rps_pkg::RPS_POR_LOCK: begin
        d.cnt = q.cnt + 10'h001;
        if (drive_done) begin
          d.state = rps_pkg::RPS_RELEASE;
          d.cnt   = '0;
        end
      end
      rps_pkg::RPS_IDLE: begin
        d.cnt = '0;
        if (!pin_high) begin
          d.ext_pend = 1'b1;
        end
        if (q.ext_pend) begin
          d.tmo = q.tmo + 6'h01;
        end
        if (i_int_rst_req) begin
          d.state    = rps_pkg::RPS_DRIVE;
          d.ext_pend = 1'b0;
          d.tmo      = '0;
        end else if (q.ext_pend &&
                     (i_bus_cycle_end || q.tmo == `RPS_BUS_TMO_LAST)) begin
          // hold off so a write in flight finishes first
          d.state    = rps_pkg::RPS_EXT_WAIT;
          d.ext_pend = 1'b0;
          d.tmo      = '0;
        end
      end
      rps_pkg::RPS_EXT_WAIT: begin
        // not driving here, else the release could never be seen
        if (pin_high) begin
          d.state = rps_pkg::RPS_DRIVE;
          d.cnt   = '0;
        end
      end
      rps_pkg::RPS_DRIVE: begin
        if (!drive_done) begin
          d.cnt = q.cnt + 10'h001;
        end else if (!i_int_rst_req) begin
          d.state = rps_pkg::RPS_RELEASE;
          d.cnt   = '0;
        end
      end
      rps_pkg::RPS_RELEASE: begin
        d.cnt = q.cnt + 10'h001;
        if (rel_done) begin
          d.cnt = '0;
          if (pin_high) begin
            d.state = rps_pkg::RPS_IDLE;
            d.exc   = 1'b1;
          end else begin
            d.state = rps_pkg::RPS_DRIVE;
          end
        end
      end
      default: begin
        d.state = rps_pkg::RPS_POR;
        d.cnt   = '0;
      end
    endcase

    // consecutive cycles of internal reset before modules reset
    if (!active) begin
      d.run        = '0;
      d.periph_rst = 1'b0;
    end else if (q.run != `RPS_PERIPH_RUN) begin
      d.run = q.run + 3'h1;
    end else begin
      d.periph_rst = 1'b1;
    end

    // three-state is sticky; only i_rst_n (power cycle) clears it
    if (!q.hiz) begin
      if (!i_three_state_control) begin
        d.tsc_cnt = '0;
      end else if (tsc_tick) begin
        if (q.tsc_cnt == `RPS_TSC_LAST) begin
          d.hiz = 1'b1;
        end else begin
          d.tsc_cnt = q.tsc_cnt + 4'h1;
        end
      end
    end
  end

  // clock enable stands for a running system clock output
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q       <= '0;
      q.state <= rps_pkg::RPS_POR;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_rst_pin_out = 1'b0;
  assign o_rst_pin_oe  = !q.hiz &&
                         (q.state == rps_pkg::RPS_POR ||
                          q.state == rps_pkg::RPS_POR_LOCK ||
                          q.state == rps_pkg::RPS_DRIVE);
  assign o_reset_active    = active;
  assign o_sim_pins_safe   = active || q.hiz;
  assign o_periph_rst      = q.periph_rst;
  assign o_reset_exception = q.exc;
  assign o_outputs_hiz     = q.hiz;
  // all ones clears every enable and direction bit: ports, inputs
  assign o_pin_func_en_clr = {`RPS_PORT_W{active}};
  assign o_port_dir_clr    = {`RPS_PORT_W{active}};

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n || !i_clk_en);

  sequence s_drive_end;
    q.state == rps_pkg::RPS_DRIVE && d.state != rps_pkg::RPS_DRIVE;
  endsequence

  sequence s_release_high;
    q.state == rps_pkg::RPS_RELEASE && rel_done && pin_high;
  endsequence

  sequence s_release_low;
    q.state == rps_pkg::RPS_RELEASE && rel_done && !pin_high;
  endsequence

  chk_drive_min_len: assert property (
    s_drive_end |-> drive_done && !i_int_rst_req)
    else $error("drive period left early");

  chk_drive_to_float: assert property (
    s_drive_end |=> q.state == rps_pkg::RPS_RELEASE && !o_rst_pin_oe
      ##9 q.state == rps_pkg::RPS_RELEASE)
    else $error("release window not ten cycles");

  chk_test_high_exc: assert property (
    s_release_high |=> o_reset_exception &&
      q.state == rps_pkg::RPS_IDLE)
    else $error("high pin did not start exception");

  chk_test_low_redrive: assert property (
    s_release_low |=> q.state == rps_pkg::RPS_DRIVE &&
      q.cnt == 10'h000 && o_rst_pin_oe)
    else $error("low pin not driven again");

  chk_ext_latch_drive: assert property (
    q.state == rps_pkg::RPS_EXT_WAIT && pin_high |=>
      q.state == rps_pkg::RPS_DRIVE && q.cnt == 10'h000)
    else $error("released pin did not start drive");

  chk_ext_postpone: assert property (
    q.state == rps_pkg::RPS_IDLE && q.ext_pend && !i_int_rst_req &&
      !i_bus_cycle_end && q.tmo != `RPS_BUS_TMO_LAST |=>
      q.state == rps_pkg::RPS_IDLE)
    else $error("external reset taken mid bus cycle");

  chk_por_until_lock: assert property (
    q.state == rps_pkg::RPS_POR && !i_synth_lock |=>
      q.state == rps_pkg::RPS_POR)
    else $error("power-on left before lock");

  chk_periph_four: assert property (
    $rose(o_periph_rst) |-> $past(active, 1) && $past(active, 4) &&
      q.run == `RPS_PERIPH_RUN)
    else $error("module reset before four cycles");

  chk_pins_safe: assert property (
    active |-> o_sim_pins_safe && &o_pin_func_en_clr && &o_port_dir_clr)
    else $error("pin defaults not forced in reset");

  chk_tsc_ten_ticks: assert property (
    $rose(o_outputs_hiz) |-> $past(q.tsc_cnt) == `RPS_TSC_LAST &&
      $past(i_three_state_control))
    else $error("three-state taken before ten ticks");

  chk_hiz_sticky: assert property (
    o_outputs_hiz |=> o_outputs_hiz && !o_rst_pin_oe)
    else $error("three-state left without power cycle");

  chk_int_wins_pend: assert property (
    q.state == rps_pkg::RPS_IDLE && i_int_rst_req |=>
      q.state == rps_pkg::RPS_DRIVE && q.cnt == 10'h000 && !q.ext_pend)
    else $error("internal request not taken at once");

  chk_ext_wait_float: assert property (
    q.state == rps_pkg::RPS_EXT_WAIT |-> !o_rst_pin_oe)
    else $error("pin driven while external holds it");

  chk_ext_hold_wait: assert property (
    q.state == rps_pkg::RPS_EXT_WAIT && !pin_high |=>
      q.state == rps_pkg::RPS_EXT_WAIT)
    else $error("external wait left with pin low");

  chk_pend_latch: assert property (
    q.state == rps_pkg::RPS_IDLE && !pin_high |=>
      q.ext_pend || q.state != rps_pkg::RPS_IDLE)
    else $error("low pin not latched as pending");

  chk_exc_one_cycle: assert property (
    o_reset_exception |=> !o_reset_exception)
    else $error("exception pulse longer than one cycle");

  chk_exc_only_test: assert property (
    o_reset_exception |-> $past(q.state) == rps_pkg::RPS_RELEASE &&
      $past(pin_high))
    else $error("exception without high pin test");

  chk_pin_out_low: assert property (
    o_rst_pin_oe |-> !o_rst_pin_out)
    else $error("reset pin driven high");

  chk_drive_oe: assert property (
    q.state == rps_pkg::RPS_DRIVE && !q.hiz |-> o_rst_pin_oe)
    else $error("drive state without pin drive");

  chk_release_float: assert property (
    q.state == rps_pkg::RPS_RELEASE |-> !o_rst_pin_oe)
    else $error("pin driven during float");

  chk_periph_clear: assert property (
    !active |=> !o_periph_rst)
    else $error("module reset held after idle");

  chk_tsc_restart: assert property (
    !q.hiz && !i_three_state_control |=> q.tsc_cnt == 4'h0 && !q.hiz)
    else $error("three-state count not restarted");

  chk_lock_drive_len: assert property (
    q.state == rps_pkg::RPS_POR_LOCK && drive_done |=>
      q.state == rps_pkg::RPS_RELEASE)
    else $error("power-on drive not ended after lock");

endmodule

// [tb/rps_ext_dev.sv]
// external device sharing the open-drain reset line, with pull-up
module rps_ext_dev (
  input  wire logic i_oe,
  input  wire logic i_hold_low,
  output logic      o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-up: a released line reads high, any driver pulls it low
  assign o_level = !(i_oe || i_hold_low);
endmodule

// [tb/tb.sv]
// self-checking bench of the reset pin sequencer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, int_req = 1'b0;
  logic       bus_end = 1'b0, lock = 1'b0, src_sel = 1'b1;
  logic       ext_pulse = 1'b0, three_state_control = 1'b0, hold_low = 1'b0;
  logic       pin, pout, oe, act, safe, prst, exc, hiz;
  logic [7:0] fclr, dclr;
  int         failures = 0, tests_run = 0, cycles = 0, n;

  always #2.5 clk = ~clk;

  rps_sequencer i_rps_sequencer (
    .i_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_rst_pin_in(pin), .o_rst_pin_out(pout), .o_rst_pin_oe(oe),
    .i_int_rst_req(int_req), .i_bus_cycle_end(bus_end),
    .i_synth_lock(lock), .i_clock_source_select(src_sel),
    .i_ext_clk_pulse(ext_pulse), .i_three_state_control(three_state_control),
    .o_reset_active(act), .o_sim_pins_safe(safe), .o_periph_rst(prst),
    .o_reset_exception(exc), .o_outputs_hiz(hiz),
    .o_pin_func_en_clr(fclr), .o_port_dir_clr(dclr));

  rps_ext_dev i_rps_ext_dev (.i_oe(oe), .i_hold_low(hold_low), .o_level(pin));

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, the whole run needs about 4100 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic count_oe(input logic v, output int k);
    k = 0;
    while (oe === v && k < 4000) begin
      k++;
      cyc(1);
    end
  endtask

  // release, test high, one-cycle exception pulse, then idle
  task automatic finish_seq;
    int k;
    k = 0;
    while (exc !== 1'b1 && k < 16) begin
      k++;
      cyc(1);
    end
    check(k >= 9 && k <= 13, 1'b1, "float length");
    cyc(1);
    check(exc, 1'b0, "exception width");
    cyc(2);
    check(act, 1'b0, "not idle");
    check(fclr | dclr, 8'h00, "clear buses stuck");
  endtask

  task automatic t_por;
    cyc(20);
    check(oe, 1'b1, "pin free before lock");
    check(pout, 1'b0, "pin data not low");
    check(safe, 1'b1, "pins unsafe in reset");
    check(prst, 1'b1, "modules not in reset");
    check(fclr & dclr, 8'hff, "defaults not cleared");
    lock = 1'b1;
    count_oe(1'b1, n);
    check(n >= 511 && n <= 514, 1'b1, "power-on drive length");
    finish_seq();
    check(prst, 1'b0, "modules held");
    $display("test power_on done");
  endtask

  task automatic t_int;
    int_req = 1'b1;
    cyc(1);
    int_req = 1'b0;
    cyc(1);
    check(prst, 1'b0, "module reset too early");
    cyc(8);
    check(prst, 1'b1, "module reset missing");
    cyc(90);
    clk_en = 1'b0;
    cyc(50);
    check(oe, 1'b1, "drive lost while clock stopped");
    clk_en = 1'b1;
    count_oe(1'b1, n);
    n = n + 150;
    check(n >= 560 && n <= 565, 1'b1, "internal drive length");
    finish_seq();
    int_req = 1'b1;
    cyc(700);
    check(oe, 1'b1, "drive ended under request");
    int_req = 1'b0;
    count_oe(1'b1, n);
    check(n <= 3, 1'b1, "drive outlived request");
    finish_seq();
    $display("test internal done");
  endtask

  task automatic t_ext;
    hold_low = 1'b1;
    cyc(30);
    check(act, 1'b0, "no wait for bus cycle");
    cyc(70);
    check(act, 1'b1, "external reset lost");
    check(oe, 1'b0, "driving over external");
    hold_low = 1'b0;
    cyc(6);
    check(oe, 1'b1, "no drive after release");
    count_oe(1'b1, n);
    check(n >= 505 && n <= 512, 1'b1, "stretch length");
    finish_seq();
    // second external reset, released early by a bus cycle end
    hold_low = 1'b1;
    cyc(3);
    check(act, 1'b0, "pending taken without bus end");
    bus_end = 1'b1;
    cyc(1);
    bus_end = 1'b0;
    check(act, 1'b1, "bus end ignored");
    hold_low = 1'b0;
    cyc(6);
    check(oe, 1'b1, "no drive after release");
    count_oe(1'b1, n);
    check(n >= 505 && n <= 512, 1'b1, "stretch length");
    finish_seq();
    $display("test external done");
  endtask

  task automatic t_retest;
    int_req = 1'b1;
    hold_low = 1'b1;
    cyc(1);
    int_req = 1'b0;
    count_oe(1'b1, n);
    check(n >= 510 && n <= 514, 1'b1, "first drive length");
    count_oe(1'b0, n);
    check(n >= 10 && n <= 12, 1'b1, "float before retest");
    hold_low = 1'b0;
    count_oe(1'b1, n);
    check(n >= 510 && n <= 514, 1'b1, "second drive length");
    finish_seq();
    $display("test retest done");
  endtask

  task automatic t_tsc;
    three_state_control = 1'b1;
    cyc(5);
    three_state_control = 1'b0;
    cyc(1);
    three_state_control = 1'b1;
    cyc(8);
    check(hiz, 1'b0, "count not restarted");
    cyc(4);
    check(hiz, 1'b1, "drivers not floated");
    check(safe, 1'b1, "pins unsafe");
    three_state_control = 1'b0;
    cyc(5);
    check(hiz, 1'b1, "left three-state");
    // restart with the external clock strap
    rst_n = 1'b0;
    src_sel = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    three_state_control = 1'b1;
    cyc(30);
    check(hiz, 1'b0, "counted system clock");
    repeat (9) begin
      ext_pulse = 1'b1;
      cyc(1);
      ext_pulse = 1'b0;
      cyc(1);
    end
    check(hiz, 1'b0, "floated early");
    ext_pulse = 1'b1;
    cyc(1);
    ext_pulse = 1'b0;
    cyc(2);
    check(hiz, 1'b1, "tenth pulse ignored");
    $display("test three_state done");
  endtask

  initial begin
    cyc(12);
    rst_n = 1'b1;
    t_por();
    t_int();
    t_ext();
    t_retest();
    t_tsc();
    give_verdict();
  end
endmodule
